// ---- hw/umc_mode_ctrl.sv ----
// umc_mode_ctrl: mode register, pin ownership, power modes, infrared codec, wake and auto rate
// assumes pins and power mode inputs are synchronous to clock_i; baud16_tick_i comes from the rate divider
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
module umc_mode_ctrl #(
	parameter int CNT_W = 16
) (
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	input  wire logic [1:0]             addr_i,
	input  wire logic [15:0]            wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic      [15:0]            rdata_o,
	input  wire logic                   idle_i,
	input  wire logic                   sleep_i,
	input  wire logic                   baud16_tick_i,
	input  wire logic                   tx_data_i,
	input  wire logic                   tx_busy_i,
	input  wire logic                   rx_room_i,
	input  wire logic                   bclk_i,
	input  wire logic                   rx_pin_i,
	input  wire logic                   cts_pin_i,
	output logic                        tx_pin_o,
	output logic                        tx_oe_o,
	output logic                        rts_pin_o,
	output logic                        rts_oe_o,
	output logic                        bclk_pin_o,
	output logic                        bclk_oe_o,
	output umc_pkg::umc_pins_t          own_o,
	output logic                        rx_core_o,
	output logic                        cts_core_o,
	output logic                        run_o,
	output logic                        ir_active_o,
	output logic                        loopback_o,
	output logic                        rate_valid_o,
	output logic      [CNT_W-1:0]       rate_o,
	output logic                        irq_o,
	output logic                        wake_req_o
);
	initial begin
		if (CNT_W < 4 || CNT_W > 16) begin
			$error("CNT_W must lie in 4..16");
		end
	end

	umc_pkg::umc_mode_t     mode_r;
	umc_pkg::umc_mode_t     mode_nxt;
	umc_pkg::umc_ab_state_t ab_r;
	umc_pkg::umc_ab_state_t ab_nxt;
	logic [1:0]             stat_r;
	logic [1:0]             mask_r;
	logic [15:0]            rdata_r;
	logic                   rx_q_r;
	logic                   wake_armed_r;
	logic [CNT_W-1:0]       cnt_r;
	logic [2:0]             falls_r;
	logic [CNT_W-1:0]       rate_r;
	logic                   rate_valid_r;
	logic [3:0]             ir_phase_r;
	logic [3:0]             ir_hold_r;
	logic                   tx_pin_r;
	logic                   rx_core_r;

	wire        wr_mode   = wr_i && (addr_i == umc_pkg::OFS_MODE);
	wire        wr_stat   = wr_i && (addr_i == umc_pkg::OFS_STAT);
	wire        wr_mask   = wr_i && (addr_i == umc_pkg::OFS_MASK);
	wire        en        = mode_r.port_enable;
	wire [1:0]  sel       = mode_r.pin_select_field;
	wire        rx_fall   = rx_q_r && !rx_pin_i;
	wire        rx_rise   = !rx_q_r && rx_pin_i;
	// idle halts only when asked; sleep always stops the clocked port
	wire        idle_stop = idle_i && mode_r.stop_in_idle;
	wire        run       = en && !idle_stop && !sleep_i;
	wire        wake_det  = sleep_i && en && mode_r.wake_enable && rx_fall;
	wire        wake_clr  = wake_armed_r && rx_rise;
	// the fall that closes the span is not yet in falls_r when it arrives
	wire        ab_done   = (ab_r == umc_pkg::AB_MEAS) && rx_fall && (falls_r == umc_pkg::AB_FALLS - 3'h1);
	wire [1:0]  events    = {ab_done, wake_det};
	// the codec needs the 16x tick, so the high speed rate select blocks it
	wire        ir_on     = en && mode_r.infrared_codec_enable && !mode_r.high_speed_rate_select;
	wire        loop_on   = en && mode_r.loopback_select;
	wire        ir_tx     = !tx_data_i && (ir_phase_r < umc_pkg::IR_PULSE);
	wire        ir_rx     = (ir_hold_r == 4'h0);
	wire        rx_line   = mode_r.rx_invert ? !rx_pin_i : rx_pin_i;
	wire        rts_level = mode_r.rts_pin_mode ? tx_busy_i : rx_room_i;

	// ownership is computed only from an enabled port
	umc_pkg::umc_pins_t own;
	assign own.tx   = en;
	assign own.rx   = en;
	assign own.cts  = en && (sel == umc_pkg::SEL_FULL);
	assign own.rts  = en && ((sel == umc_pkg::SEL_FULL) || (sel == umc_pkg::SEL_RTS));
	assign own.bclk = en && (sel == umc_pkg::SEL_BCLK);

	wire [15:0] rd_mux =
		(addr_i == umc_pkg::OFS_MODE) ? (mode_r & umc_pkg::MODE_WMSK) :
		(addr_i == umc_pkg::OFS_STAT) ? {14'h0000, stat_r} :
		(addr_i == umc_pkg::OFS_MASK) ? {14'h0000, mask_r} :
		16'(rate_r);

	always_comb begin
		mode_nxt = mode_r;
		if (wake_clr) begin
			mode_nxt.wake_enable = 1'b0;
		end
		if (ab_done) begin
			mode_nxt.auto_rate_enable = 1'b0;
		end
		// a software write in the same cycle wins over the hardware clear
		if (wr_mode) begin
			mode_nxt = umc_pkg::umc_mode_t'(wdata_i & umc_pkg::MODE_WMSK);
		end
	end

	// measures the span from the start bit fall to the fifth fall of the sync char, eight bit times
	always_comb begin
		ab_nxt = ab_r;
		unique case (ab_r)
			umc_pkg::AB_IDLE: begin
				if (run && mode_r.auto_rate_enable) begin
					ab_nxt = umc_pkg::AB_WAIT;
				end
			end
			umc_pkg::AB_WAIT: begin
				if (!run || !mode_r.auto_rate_enable) begin
					ab_nxt = umc_pkg::AB_IDLE;
				end else if (rx_fall) begin
					ab_nxt = umc_pkg::AB_MEAS;
				end
			end
			umc_pkg::AB_MEAS: begin
				if (!run || !mode_r.auto_rate_enable || ab_done) begin
					ab_nxt = umc_pkg::AB_IDLE;
				end
			end
			default: begin
				ab_nxt = umc_pkg::AB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_r <= umc_pkg::umc_mode_t'(umc_pkg::MODE_RST);
			ab_r   <= umc_pkg::AB_IDLE;
			stat_r <= umc_pkg::EV_RST;
			mask_r <= umc_pkg::EV_RST;
		end else begin
			mode_r <= mode_nxt;
			ab_r   <= ab_nxt;
			// event set wins over a write-one clear
			stat_r <= (stat_r & ~(wr_stat ? wdata_i[1:0] : 2'h0)) | events;
			if (wr_mask) begin
				mask_r <= wdata_i[1:0];
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rd_i ? rd_mux : 16'h0000;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_q_r       <= 1'b1;
			wake_armed_r <= 1'b0;
		end else begin
			rx_q_r <= rx_pin_i;
			if (wake_det) begin
				wake_armed_r <= 1'b1;
			end else if (wake_clr || !mode_r.wake_enable) begin
				wake_armed_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_r        <= '0;
			falls_r      <= 3'h0;
			rate_r       <= '0;
			rate_valid_r <= 1'b0;
		end else begin
			if (ab_r != umc_pkg::AB_MEAS) begin
				cnt_r   <= '0;
				falls_r <= 3'h0;
			end else begin
				// saturates rather than wraps on a very slow sender
				if (cnt_r != '1) begin
					cnt_r <= cnt_r + 1'b1;
				end
				if (rx_fall) begin
					falls_r <= falls_r + 3'h1;
				end
			end
			if (ab_done) begin
				rate_r       <= cnt_r >> umc_pkg::AB_SHIFT;
				rate_valid_r <= 1'b1;
			end else if (ab_nxt == umc_pkg::AB_MEAS && ab_r == umc_pkg::AB_WAIT) begin
				rate_valid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir_phase_r <= 4'h0;
			ir_hold_r  <= 4'h0;
		end else if (!run || !ir_on) begin
			ir_phase_r <= 4'h0;
			ir_hold_r  <= 4'h0;
		end else begin
			// the phase runs free so sending still encodes while the receive line is high
			if (baud16_tick_i) begin
				ir_phase_r <= ir_phase_r + 4'h1;
			end
			if (rx_pin_i) begin
				ir_hold_r <= umc_pkg::IR_HOLD;
			end else if (baud16_tick_i && ir_hold_r != 4'h0) begin
				ir_hold_r <= ir_hold_r - 4'h1;
			end
		end
	end

	// loopback keeps the tx pin idle so the line peer sees nothing
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_pin_r  <= 1'b1;
			rx_core_r <= 1'b1;
		end else begin
			tx_pin_r  <= (!run || loop_on) ? !ir_on : (ir_on ? ir_tx : tx_data_i);
			rx_core_r <= !run ? 1'b1 : (loop_on ? tx_data_i : (ir_on ? ir_rx : rx_line));
		end
	end

	assign rdata_o      = rdata_r;
	assign tx_pin_o     = tx_pin_r;
	assign tx_oe_o      = !own.tx;
	assign rts_pin_o    = !rts_level;                                      // pin is active low
	assign rts_oe_o     = !own.rts;
	assign bclk_pin_o   = bclk_i;
	assign bclk_oe_o    = !own.bclk;
	assign own_o        = own;
	assign rx_core_o    = rx_core_r;
	assign cts_core_o   = own.cts ? cts_pin_i : 1'b0;
	assign run_o        = run;
	assign ir_active_o  = ir_on;
	assign loopback_o   = loop_on;
	assign rate_valid_o = rate_valid_r;
	assign rate_o       = rate_r;
	assign irq_o        = |(stat_r & mask_r);
	assign wake_req_o   = irq_o;

	property p_own_off;
		@(posedge clock_i) disable iff (!rst_n_i) !mode_r.port_enable |-> (own_o == '0) && tx_oe_o && rts_oe_o;
	endproperty
	a_own_off: assert property (p_own_off) else $error("pins owned while disabled");

	property p_sel_bclk;
		@(posedge clock_i) disable iff (!rst_n_i)
			(en && sel == umc_pkg::SEL_BCLK) |-> own_o.bclk && !own_o.cts && !own_o.rts && !bclk_oe_o;
	endproperty
	a_sel_bclk: assert property (p_sel_bclk) else $error("bad pin map for select 11");

	property p_idle_halt;
		@(posedge clock_i) disable iff (!rst_n_i) (idle_i && mode_r.stop_in_idle) |-> !run_o;
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("port ran in idle");

	property p_idle_run;
		@(posedge clock_i) disable iff (!rst_n_i) (en && idle_i && !sleep_i && !mode_r.stop_in_idle) |-> run_o;
	endproperty
	a_idle_run: assert property (p_idle_run) else $error("port stopped in idle");

	property p_sleep_stop;
		@(posedge clock_i) disable iff (!rst_n_i) sleep_i |-> !run_o && (ab_r != umc_pkg::AB_MEAS || !$past(run));
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("port ran in sleep");

	property p_ir_gate;
		@(posedge clock_i) disable iff (!rst_n_i) (run && mode_r.infrared_codec_enable && mode_r.high_speed_rate_select
			&& !loop_on) |-> !ir_active_o ##1 (tx_pin_o == $past(tx_data_i));
	endproperty
	a_ir_gate: assert property (p_ir_gate) else $error("codec on outside 16x mode");

	property p_wake_irq;
		@(posedge clock_i) disable iff (!rst_n_i) wake_det |=> stat_r[umc_pkg::EV_WAKE] && (mask_r[0] == irq_o || stat_r[1]);
	endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake edge lost");

	property p_wake_clr;
		@(posedge clock_i) disable iff (!rst_n_i) (wake_armed_r && rx_rise && !wr_mode) |=> !mode_r.wake_enable;
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake enable not cleared");

	property p_ab_clr;
		@(posedge clock_i) disable iff (!rst_n_i) (ab_done && !wr_mode) |=> !mode_r.auto_rate_enable && rate_valid_o;
	endproperty
	a_ab_clr: assert property (p_ab_clr) else $error("auto rate bit not cleared");

	property p_rsvd;
		@(posedge clock_i) disable iff (!rst_n_i) $past(rd_i) |-> (rdata_o[14] == 1'b0) && (rdata_o[10] == 1'b0);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");

	property p_loop;
		@(posedge clock_i) disable iff (!rst_n_i) (run && loop_on) |=> rx_core_o == $past(tx_data_i);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback path broken");

	property p_rts_simplex;
		@(posedge clock_i) disable iff (!rst_n_i) mode_r.rts_pin_mode |-> (rts_pin_o == !tx_busy_i);
	endproperty
	a_rts_simplex: assert property (p_rts_simplex) else $error("rts not low while sending");

	property p_rts_flow;
		@(posedge clock_i) disable iff (!rst_n_i) !mode_r.rts_pin_mode |-> (rts_pin_o == !rx_room_i);
	endproperty
	a_rts_flow: assert property (p_rts_flow) else $error("rts not low while room");

	property p_off_quiet;
		@(posedge clock_i) disable iff (!rst_n_i) !en |=> tx_pin_o && rx_core_o;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("disabled port moved its lines");

	property p_cts_gate;
		@(posedge clock_i) disable iff (!rst_n_i) !own_o.cts |-> !cts_core_o;
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("cts passed while not owned");

	property p_bclk_off;
		@(posedge clock_i) disable iff (!rst_n_i) (!en || sel != umc_pkg::SEL_BCLK) |-> bclk_oe_o;
	endproperty
	a_bclk_off: assert property (p_bclk_off) else $error("baud clock pin driven");

	c_wake:  cover property (@(posedge clock_i) disable iff (!rst_n_i) wake_det ##[1:200] wake_clr);
	c_auto_rate_enable: cover property (@(posedge clock_i) disable iff (!rst_n_i) ab_done);
	c_ir:    cover property (@(posedge clock_i) disable iff (!rst_n_i) ir_on && run && !tx_pin_o);
	c_rts:   cover property (@(posedge clock_i) disable iff (!rst_n_i) own_o.rts && mode_r.rts_pin_mode && !rts_pin_o);
	c_loop:  cover property (@(posedge clock_i) disable iff (!rst_n_i) run && loop_on && !rx_core_o);
endmodule : umc_mode_ctrl

// ---- hw/umc_pkg.sv ----
// umc_pkg: constants, mode register layout and pin carrier for the serial port mode control
// assumes a 16-bit register port and a system clock of 25 MHz
// Overview of operation
// - with the port enabled the serial pins go to the port as the pin select chooses, else to port latches.
// - entering idle halts the port when stop in idle is set and leaves it running when clear.
// - the infrared codec enable switches the infrared encoder and decoder into the serial path.
// - the infrared codec only works while the high speed rate select is clear (16x mode).
// - the request to send mode bit picks simplex (1) or flow control (0) for that pin.
// - pin select 11 gives tx rx baud clock, 10 tx rx cts rts, 01 tx rx rts, 00 tx rx only.
// - with wake enable set in sleep the receive pin is watched and a falling edge raises an interrupt.
// - after a wake falling edge the next rising edge on receive clears the wake enable.
// - the loopback select bit puts the port in loopback, clearing it restores normal use.
// - auto rate measures the next character, which the sender must make the sync value 0x55.
// - the auto rate bit reads zero when off or finished and hardware clears it at completion.
// - unimplemented mode register bits, 14 and 10 among them, read as zero.
// - in idle the processor stops but the port keeps running unless told to stop.
// - in sleep normal transfer stops and only the start bit wake detector stays active.
// - any enabled interrupt such as the wake event makes the device leave sleep or idle.
package umc_pkg;
	localparam int          ADDR_W    = 2;
	localparam int          DATA_W    = 16;
	localparam logic [1:0]  OFS_MODE  = 2'h0;
	localparam logic [1:0]  OFS_STAT  = 2'h1;
	localparam logic [1:0]  OFS_MASK  = 2'h2;
	localparam logic [1:0]  OFS_RATE  = 2'h3;
	localparam logic [15:0] MODE_RST  = 16'h0000;
	localparam logic [15:0] MODE_WMSK = 16'hBBFF;
	localparam logic [1:0]  EV_RST    = 2'h0;
	localparam int          EV_WAKE   = 0;
	localparam int          EV_RATE   = 1;
	localparam logic [1:0]  SEL_BCLK  = 2'h3;
	localparam logic [1:0]  SEL_FULL  = 2'h2;
	localparam logic [1:0]  SEL_RTS   = 2'h1;
	localparam logic [7:0]  SYNC_CHAR = 8'h55;
	localparam logic [2:0]  AB_FALLS  = 3'h4;
	localparam int          AB_SHIFT  = 3;
	localparam logic [3:0]  IR_PULSE  = 4'h3;
	localparam logic [3:0]  IR_HOLD   = 4'hF;

	typedef struct packed {
		logic       port_enable;
		logic       rsvd14;
		logic       stop_in_idle;
		logic       infrared_codec_enable;
		logic       rts_pin_mode;
		logic       rsvd10;
		logic [1:0] pin_select_field;
		logic       wake_enable;
		logic       loopback_select;
		logic       auto_rate_enable;
		logic       rx_invert;
		logic       high_speed_rate_select;
		logic [1:0] parity_select;
		logic       stop_select;
	} umc_mode_t;

	typedef struct packed {
		logic tx;
		logic rx;
		logic cts;
		logic rts;
		logic bclk;
	} umc_pins_t;

	typedef enum logic [1:0] {
		AB_IDLE = 2'b00,
		AB_WAIT = 2'b01,
		AB_MEAS = 2'b10
	} umc_ab_state_t;
endpackage : umc_pkg

// ---- sim/tb_uart_mode_control.sv ----
// tb_uart_mode_control: table of mode settings, then power, pin, loopback, wake, auto rate and reset tests
// assumes umc_pkg and umc_mode_ctrl compiled first; the peer model sends on the receive pin
`timescale 1ns/10ps
module tb_uart_mode_control;
	localparam int BITC = 20;
	typedef struct packed {
		logic [15:0] w;
		logic [15:0] r;
		logic [4:0]  own;
		logic        ir;
	} umc_row_t;
	logic clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, idle_i = 1'b0, sleep_i = 1'b0;
	logic tick = 1'b0, tx_data = 1'b1, tx_busy = 1'b0, rx_room = 1'b0, bclk = 1'b0, cts = 1'b0;
	logic brx = 1'b1, go = 1'b0, prx, txp, tx_oe, rts_oe, bclk_oe, irq, wake, run, ir_act, loop_o, rv;
	logic [1:0]  addr_i = 2'h0;
	logic [15:0] wdata_i = 16'h0000, rdata_o, rate, d;
	umc_pkg::umc_pins_t own;
	int bad_count = 0, comparisons = 0, cyc = 0;
	umc_row_t rows [9] = '{
		'{16'h8000, 16'h8000, 5'h18, 1'b0}, '{16'h8100, 16'h8100, 5'h1A, 1'b0},
		'{16'h8200, 16'h8200, 5'h1E, 1'b0}, '{16'h8300, 16'h8300, 5'h19, 1'b0},
		'{16'h0300, 16'h0300, 5'h00, 1'b0}, '{16'h9000, 16'h9000, 5'h18, 1'b1},
		'{16'h9008, 16'h9008, 5'h18, 1'b0}, '{16'h5C00, 16'h1800, 5'h00, 1'b0},
		'{16'h1000, 16'h1000, 5'h00, 1'b0}};

	umc_mode_ctrl #(.CNT_W(16)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
		.sleep_i(sleep_i), .baud16_tick_i(tick), .tx_data_i(tx_data), .tx_busy_i(tx_busy),
		.rx_room_i(rx_room), .bclk_i(bclk), .rx_pin_i(prx & brx), .cts_pin_i(cts),
		.tx_pin_o(txp), .tx_oe_o(tx_oe), .rts_pin_o(), .rts_oe_o(rts_oe), .bclk_pin_o(),
		.bclk_oe_o(bclk_oe), .own_o(own), .rx_core_o(), .cts_core_o(), .run_o(run),
		.ir_active_o(ir_act), .loopback_o(loop_o), .rate_valid_o(rv), .rate_o(rate),
		.irq_o(irq), .wake_req_o(wake));
	umc_peer #(.BIT_CYC(BITC)) u_peer (.clock_i(clock_i), .go_i(go), .byte_i(8'h55), .line_o(prx));

	initial begin
		forever #20 clock_i = ~clock_i;
	end
	// a free 16x tick and baud clock keep the codec and pin paths moving
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		tick <= (cyc % 16) == 0;
		bclk <= ~bclk;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [15:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	// read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask : rd
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		step(1);
		foreach (rows[i]) begin
			wr(umc_pkg::OFS_MODE, rows[i].w);
			rd(umc_pkg::OFS_MODE, rows[i].r);
			chk(16'(own), 16'(rows[i].own));
			chk(16'(tx_oe), 16'(!rows[i].w[15]));
			chk(16'({rts_oe, bclk_oe}), {14'h0000, ~rows[i].own[1:0]});
			chk(16'(ir_act), 16'(rows[i].ir));
		end
		$display("test mode table done");
		wr(umc_pkg::OFS_MODE, 16'hA000);
		idle_i <= 1'b1;
		step(1);
		chk(16'(run), 16'h0000);
		wr(umc_pkg::OFS_MODE, 16'h8000);
		chk(16'(run), 16'h0001);
		sleep_i <= 1'b1;
		step(1);
		chk(16'(run), 16'h0000);
		{idle_i, sleep_i} <= 2'b00;
		$display("test power modes done");
		wr(umc_pkg::OFS_MODE, 16'h8A00);
		tx_busy <= 1'b1;
		step(1);
		chk(16'(u_dut.rts_pin_o), 16'h0000);
		tx_busy <= 1'b0;
		step(1);
		chk(16'(u_dut.rts_pin_o), 16'h0001);
		wr(umc_pkg::OFS_MODE, 16'h8200);
		rx_room <= 1'b1;
		cts <= 1'b1;
		step(1);
		chk(16'({u_dut.rts_pin_o, u_dut.cts_core_o}), 16'h0001);
		chk(16'(u_dut.bclk_pin_o), 16'(bclk));
		$display("test request and clear pins done");
		wr(umc_pkg::OFS_MODE, 16'h8040);
		tx_data <= 1'b0;
		step(2);
		chk(16'({loop_o, u_dut.rx_core_o}), 16'h0002);
		chk(16'(txp), 16'h0001);
		tx_data <= 1'b1;
		step(2);
		chk(16'(u_dut.rx_core_o), 16'h0001);
		wr(umc_pkg::OFS_MODE, 16'h8000);
		chk(16'(loop_o), 16'h0000);
		tx_data <= 1'b0;
		step(2);
		chk(16'(txp), 16'h0000);
		tx_data <= 1'b1;
		wr(umc_pkg::OFS_MODE, 16'h9000);
		step(1);
		chk(16'(txp), 16'h0000);
		wr(umc_pkg::OFS_MODE, 16'h9008);
		step(1);
		chk(16'(txp), 16'h0001);
		wr(umc_pkg::OFS_MODE, 16'h8010);
		step(1);
		chk(16'(u_dut.rx_core_o), 16'h0000);
		$display("test loopback done");
		wr(umc_pkg::OFS_MASK, 16'h0000);
		wr(umc_pkg::OFS_MODE, 16'h8080);
		sleep_i <= 1'b1;
		brx <= 1'b0;
		step(3);
		rd(umc_pkg::OFS_STAT, 16'h0001);
		chk(16'(irq), 16'h0000);
		wr(umc_pkg::OFS_MASK, 16'h0001);
		chk(16'({irq, wake}), 16'h0003);
		brx <= 1'b1;
		step(3);
		rd(umc_pkg::OFS_MODE, 16'h8000);
		wr(umc_pkg::OFS_STAT, 16'h0001);
		chk(16'(irq), 16'h0000);
		sleep_i <= 1'b0;
		$display("test wake done");
		wr(umc_pkg::OFS_MASK, 16'h0002);
		wr(umc_pkg::OFS_MODE, 16'h8020);
		@(posedge clock_i);
		go <= 1'b1;
		@(posedge clock_i);
		go <= 1'b0;
		for (int n = 0; n < 12 * BITC && rv !== 1'b1; n++)
			step(1);
		// edge sampling may land the count one cycle either side of eight bit times
		chk(16'(rate inside {BITC - 1, BITC}), 16'h0001);
		rd(umc_pkg::OFS_MODE, 16'h8000);
		rd(umc_pkg::OFS_STAT, 16'h0002);
		chk(16'(irq), 16'h0001);
		d = rate;
		wr(umc_pkg::OFS_RATE, 16'h0000);
		rd(umc_pkg::OFS_RATE, d);
		$display("test auto rate done");
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		step(1);
		chk(16'({own, irq, rv}), 16'h0000);
		rd(umc_pkg::OFS_MODE, umc_pkg::MODE_RST);
		rd(umc_pkg::OFS_STAT, 16'h0000);
		rd(umc_pkg::OFS_MASK, 16'h0000);
		$display("test reset done");
		tally_and_finish();
	end
endmodule : tb_uart_mode_control

// ---- sim/umc_peer.sv ----
// umc_peer: remote serial sender that drives the receive line with one framed character
// assumes the bench pulses go_i for one cycle while byte_i holds the character
`timescale 1ns/10ps
module umc_peer #(
	parameter int BIT_CYC = 20
) (
	input  wire logic       clock_i,
	input  wire logic       go_i,
	input  wire logic [7:0] byte_i,
	output logic            line_o
);
	logic [9:0] frame;
	// the line rests at mark level between characters, as a pulled-up wire would
	initial line_o = 1'b1;
	always begin
		do @(posedge clock_i); while (!go_i);
		frame = {1'b1, byte_i, 1'b0};
		// start bit, eight bits lsb first, stop bit; the bench sends the sync value 0x55
		for (int i = 0; i < 10; i++) begin
			line_o <= frame[i];
			repeat (BIT_CYC) @(posedge clock_i);
		end
	end
endmodule : umc_peer
